/* logic/sicsd_pkg.sv */
// Shared constants and carrier types for the serial control, status and data register block
package sicsd_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL_FIRST = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_SECOND = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_WORD_PORT = 8'h0c;
    localparam logic [7:0] ADDR_AUDIO_CONTROL = 8'h1c;

    // ------------------------------------------------------------------
    // First control register fields
    // ------------------------------------------------------------------
    localparam int CF_SAMPLE_PHASE = 0;
    localparam int CF_IDLE_HIGH = 1;
    localparam int CF_MASTER = 2;
    localparam int CF_ENABLE = 6;
    localparam int CF_SOFT_LEVEL = 8;
    localparam int CF_SOFT_MODE = 9;
    localparam int CF_WIDE_FRAME = 11;

    // ------------------------------------------------------------------
    // Second control register fields
    // ------------------------------------------------------------------
    localparam int CS_RX_DMA = 0;
    localparam int CS_TX_DMA = 1;
    localparam int CS_SELECT_DRIVE = 2;
    localparam int CS_SELECT_PULSE = 3;
    localparam int CS_TI_MODE = 4;
    localparam int CS_FAULT_IRQ = 5;
    localparam int CS_RX_IRQ = 6;
    localparam int CS_TX_IRQ = 7;

    // ------------------------------------------------------------------
    // Flags register fields and reset value
    // ------------------------------------------------------------------
    localparam int FL_RX_FILLED = 0;
    localparam int FL_TX_EMPTY = 1;
    localparam int FL_CHANNEL = 2;
    localparam int FL_UNDERRUN = 3;
    localparam int FL_CHECKSUM = 4;
    localparam int FL_CONFIG = 5;
    localparam int FL_OVERRUN = 6;
    localparam int FL_ACTIVE = 7;
    localparam int FL_FRAMING = 8;
    localparam logic [31:0] FLAGS_RESET = 32'h00000002;

    // Audio control register field
    localparam int AC_AUDIO_SEL = 11;

    // Frame sizes in bits
    localparam logic [4:0] NARROW_BITS = 5'h08;
    localparam logic [4:0] WIDE_BITS = 5'h10;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sicsd_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } sicsd_wb_rsp_s;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic select_in;
    } sicsd_link_in_s;

    typedef struct packed {
        logic miso;
        logic select_out;
        logic select_oe;
    } sicsd_link_out_s;

endpackage

/* logic/sicsd_regs.sv */
// Serial control, status and data registers with a slave-mode frame shifter behind classic Wishbone
`timescale 1ns/10ps

module sicsd_regs
    import sicsd_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire sicsd_wb_req_s WB_REQ,
    output sicsd_wb_rsp_s WB_RSP,
    input wire sicsd_link_in_s LINK_IN,
    output sicsd_link_out_s LINK_OUT,
    input wire logic CHECKSUM_MISMATCH,
    output logic IRQ,
    output logic TX_DMA_REQ,
    output logic RX_DMA_REQ
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        // Link pin synchronisers; sck keeps a third stage for the edge finder
        logic [2:0] sck_sync;
        logic [1:0] mosi_sync;
        logic [1:0] select_sync;
        logic [15:0] control_first;
        logic [7:0] control_second;
        logic audio_sel;
        logic [15:0] tx_buf;
        logic [15:0] rx_buf;
        logic [15:0] tx_shift;
        logic [15:0] rx_shift;
        logic [4:0] bit_cnt;
        logic loaded;
        logic frame_on_q;
        logic tx_empty_flag;
        logic rx_filled_flag;
        logic rx_overrun_flag;
        logic word_read_seen;
        logic config_fault_flag;
        logic flags_touched;
        logic checksum_mismatch_flag;
        logic tx_underrun_flag;
        logic framing_fault_flag;
        logic audio_channel_side;
        logic select_pulse_hold;
        logic ack;
        logic [31:0] rd_dat;
        logic irq;
        logic tx_dma;
        logic rx_dma;
        logic miso;
        logic select_out;
        logic select_oe;
    } sicsd_state_s;

    sicsd_state_s s;
    sicsd_state_s next_s;

    // Byte-lane merge for a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                               input logic [3:0] sel);
        logic [15:0] r;
        // Lanes 2 and 3 hold no register bits and are ignored
        r = old_v;
        if (sel[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    // Keep only the bits a frame of the current width carries
    function automatic logic [15:0] frame_mask(input logic [15:0] v, input logic wide);
        return wide ? v : {8'h00, v[7:0]};
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic access;
    logic wr;
    logic rd;
    logic wide;
    logic audio;
    logic ti_mode;
    logic master;
    logic select_level;
    logic frame_on;
    logic sck_rise;
    logic sck_fall;
    logic lead_edge;
    logic trail_edge;
    logic sample_edge;
    logic shift_edge;
    logic engine_on;
    logic [4:0] frame_bits;
    logic [4:0] cnt_plus;
    logic [15:0] rx_next;
    logic [31:0] flags_view;

    always_comb begin
        next_s = s;

        // Link pins pass two flops; the third stage only serves the edge finder
        next_s.sck_sync = {s.sck_sync[1:0], LINK_IN.sck};
        next_s.mosi_sync = {s.mosi_sync[0], LINK_IN.mosi};
        next_s.select_sync = {s.select_sync[0], LINK_IN.select_in};

        // A request is taken only while ack is low, so a held strobe is not taken twice
        access = WB_REQ.cyc & WB_REQ.stb & ~s.ack;
        wr = access & WB_REQ.we;
        rd = access & ~WB_REQ.we;
        wide = s.control_first[CF_WIDE_FRAME];
        audio = s.audio_sel;
        ti_mode = s.control_second[CS_TI_MODE] & ~audio;
        master = s.control_first[CF_MASTER];
        frame_bits = wide ? WIDE_BITS : NARROW_BITS;

        // Soft select only counts outside TI framing
        select_level = (s.control_first[CF_SOFT_MODE] & ~ti_mode) ? s.control_first[CF_SOFT_LEVEL]
                                                                   : s.select_sync[1];

        // Snapshot of the flags as software sees them
        flags_view = 32'h00000000;
        flags_view[FL_RX_FILLED] = s.rx_filled_flag;
        flags_view[FL_TX_EMPTY] = s.tx_empty_flag;
        flags_view[FL_CHANNEL] = s.audio_channel_side;
        flags_view[FL_UNDERRUN] = s.tx_underrun_flag;
        flags_view[FL_CHECKSUM] = s.checksum_mismatch_flag;
        flags_view[FL_CONFIG] = s.config_fault_flag;
        flags_view[FL_OVERRUN] = s.rx_overrun_flag;
        flags_view[FL_ACTIVE] = s.bit_cnt != 5'h00 || s.loaded;
        flags_view[FL_FRAMING] = s.framing_fault_flag;

        // ------------------------------------------------------------------
        // Bus side: one wait-free answer the cycle after the strobe
        // ------------------------------------------------------------------
        next_s.ack = access;
        // The select pulse lasts one cycle unless a word write renews it
        next_s.select_pulse_hold = 1'b0;
        if (rd) begin
            case (WB_REQ.adr)
                ADDR_CONTROL_FIRST: next_s.rd_dat = {16'h0000, s.control_first};
                ADDR_CONTROL_SECOND: next_s.rd_dat = {24'h000000, s.control_second};
                ADDR_FLAGS: next_s.rd_dat = flags_view;
                ADDR_WORD_PORT: next_s.rd_dat = {16'h0000, frame_mask(s.rx_buf, wide)};
                ADDR_AUDIO_CONTROL: next_s.rd_dat = {20'h00000, s.audio_sel, 11'h000};
                default: next_s.rd_dat = 32'h00000000;
            endcase
        end else if (access) begin
            next_s.rd_dat = 32'h00000000;
        end

        // Read-side effects; any flags access, read or write, marks the flags as touched
        if (rd && WB_REQ.adr == ADDR_WORD_PORT) begin
            next_s.rx_filled_flag = 1'b0;
            next_s.word_read_seen = 1'b1;
        end
        if (access && WB_REQ.adr == ADDR_FLAGS) begin
            next_s.flags_touched = 1'b1;
        end
        if (rd && WB_REQ.adr == ADDR_FLAGS) begin
            next_s.tx_underrun_flag = 1'b0;
            if (s.word_read_seen) begin
                next_s.rx_overrun_flag = 1'b0;
                next_s.word_read_seen = 1'b0;
            end
        end

        // Write-side effects
        if (wr) begin
            case (WB_REQ.adr)
                ADDR_CONTROL_FIRST: begin
                    next_s.control_first = lane_merge(s.control_first, WB_REQ.dat[15:0], WB_REQ.sel);
                    if (s.flags_touched) begin
                        next_s.config_fault_flag = 1'b0;
                        next_s.flags_touched = 1'b0;
                    end
                end
                ADDR_CONTROL_SECOND: begin
                    if (WB_REQ.sel[0]) begin
                        next_s.control_second = WB_REQ.dat[7:0];
                    end
                end
                ADDR_FLAGS: begin
                    // Writing 0 clears; writing 1 leaves the flag alone
                    if (WB_REQ.sel[1] && !WB_REQ.dat[FL_FRAMING]) begin
                        next_s.framing_fault_flag = 1'b0;
                    end
                    if (WB_REQ.sel[0] && !WB_REQ.dat[FL_CHECKSUM]) begin
                        next_s.checksum_mismatch_flag = 1'b0;
                    end
                end
                ADDR_WORD_PORT: begin
                    next_s.tx_buf = frame_mask(lane_merge(s.tx_buf, WB_REQ.dat[15:0], WB_REQ.sel),
                                               wide);
                    next_s.tx_empty_flag = 1'b0;
                    next_s.select_pulse_hold = s.control_second[CS_SELECT_PULSE] & master;
                end
                ADDR_AUDIO_CONTROL: begin
                    if (WB_REQ.sel[1]) begin
                        next_s.audio_sel = WB_REQ.dat[AC_AUDIO_SEL];
                    end
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------------
        // Link side: slave shifter clocked by edges of the sampled link clock
        // ------------------------------------------------------------------
        // TI framing marks a frame by a high select, plain SPI by a low one
        frame_on = ti_mode ? select_level : ~select_level;
        next_s.frame_on_q = frame_on;
        sck_rise = s.sck_sync[1] & ~s.sck_sync[2];
        sck_fall = ~s.sck_sync[1] & s.sck_sync[2];
        lead_edge = s.control_first[CF_IDLE_HIGH] ? sck_fall : sck_rise;
        trail_edge = s.control_first[CF_IDLE_HIGH] ? sck_rise : sck_fall;
        sample_edge = s.control_first[CF_SAMPLE_PHASE] ? trail_edge : lead_edge;
        shift_edge = s.control_first[CF_SAMPLE_PHASE] ? lead_edge : trail_edge;
        engine_on = s.control_first[CF_ENABLE] & ~master & frame_on;
        cnt_plus = s.bit_cnt + 5'h01;
        rx_next = {s.rx_shift[14:0], s.mosi_sync[1]};

        // Select dropping mid-frame aborts the word; framed modes report it
        if (!frame_on && s.frame_on_q && (s.bit_cnt != 5'h00)) begin
            next_s.bit_cnt = 5'h00;
            next_s.loaded = 1'b0;
            if (ti_mode || audio) begin
                next_s.framing_fault_flag = 1'b1;
            end
        end
        // A TI sync pulse arriving inside a word is a framing fault too
        if (ti_mode && frame_on && !s.frame_on_q && (s.bit_cnt != 5'h00)) begin
            next_s.framing_fault_flag = 1'b1;
            next_s.bit_cnt = 5'h00;
        end

        // Outside a running slave frame nothing may stay loaded: a stale load would
        // keep the busy flag up and make the next frame skip its transmit word
        if (!engine_on) begin
            next_s.bit_cnt = 5'h00;
            next_s.loaded = 1'b0;
        end

        // Limitation: only the slave role shifts; master mode drives select and reports faults
        if (engine_on) begin
            // Pick up the transmit word at the start of each frame
            if (s.bit_cnt == 5'h00 && !s.loaded) begin
                next_s.loaded = 1'b1;
                if (!next_s.tx_empty_flag) begin
                    next_s.tx_shift = next_s.tx_buf;
                    next_s.tx_empty_flag = 1'b1;
                end else begin
                    next_s.tx_shift = 16'h0000;
                    if (audio) begin
                        next_s.tx_underrun_flag = 1'b1;
                    end
                end
            end
            // Shifting before the first sample would skip the first bit
            if (shift_edge && s.bit_cnt != 5'h00) begin
                next_s.tx_shift = {s.tx_shift[14:0], 1'b0};
            end
            if (sample_edge) begin
                next_s.rx_shift = rx_next;
                next_s.bit_cnt = cnt_plus;
                if (cnt_plus == frame_bits) begin
                    next_s.bit_cnt = 5'h00;
                    next_s.loaded = 1'b0;
                    if (audio) begin
                        next_s.audio_channel_side = ~s.audio_channel_side;
                    end
                    // Old word wins; the fresh one is lost
                    if (next_s.rx_filled_flag) begin
                        next_s.rx_overrun_flag = 1'b1;
                    end else begin
                        next_s.rx_buf = frame_mask(rx_next, wide);
                        next_s.rx_filled_flag = 1'b1;
                    end
                end
            end
        end
        // Outside audio mode the side stays parked at left
        if (!audio) begin
            next_s.audio_channel_side = 1'b0;
        end

        // Hardware sets come last so they win over a same-cycle clear
        if (master && s.control_first[CF_ENABLE] && !audio && !select_level) begin
            next_s.config_fault_flag = 1'b1;
        end
        if (CHECKSUM_MISMATCH && !audio) begin
            next_s.checksum_mismatch_flag = 1'b1;
        end

        // ------------------------------------------------------------------
        // Registered outputs from the updated state
        // ------------------------------------------------------------------
        // Interrupt is a level that stays up until software removes the cause
        next_s.irq = (next_s.control_second[CS_TX_IRQ] & next_s.tx_empty_flag)
                   | (next_s.control_second[CS_RX_IRQ] & next_s.rx_filled_flag)
                   | (next_s.control_second[CS_FAULT_IRQ] & (next_s.checksum_mismatch_flag
                      | next_s.config_fault_flag | next_s.rx_overrun_flag | next_s.tx_underrun_flag));
        // DMA requests follow the buffer flags as levels
        next_s.tx_dma = next_s.control_second[CS_TX_DMA] & next_s.tx_empty_flag;
        next_s.rx_dma = next_s.control_second[CS_RX_DMA] & next_s.rx_filled_flag;
        // MSB leaves first, so the top bit of the active width drives the pin
        next_s.miso = wide ? next_s.tx_shift[15] : next_s.tx_shift[7];
        // Select idles high; low while master is enabled, except a pulse between words
        next_s.select_out = ~(next_s.control_first[CF_MASTER] & next_s.control_first[CF_ENABLE])
                          | next_s.select_pulse_hold;
        next_s.select_oe = next_s.control_second[CS_SELECT_DRIVE] & next_s.control_first[CF_MASTER];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s <= '0;
            s.sck_sync <= 3'h0;
            // Select idles high; starting there avoids a false frame start after reset
            s.select_sync <= 2'h3;
            s.frame_on_q <= 1'b0;
            s.tx_empty_flag <= FLAGS_RESET[FL_TX_EMPTY];
            s.select_out <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Ports come straight from the state flops
    assign WB_RSP.ack = s.ack;
    assign WB_RSP.dat = s.rd_dat;
    assign LINK_OUT.miso = s.miso;
    assign LINK_OUT.select_out = s.select_out;
    assign LINK_OUT.select_oe = s.select_oe;
    assign IRQ = s.irq;
    assign TX_DMA_REQ = s.tx_dma;
    assign RX_DMA_REQ = s.rx_dma;

endmodule

/* test/sicsd_props.sv */
// Concurrent checks on the ports of the serial register block
`timescale 1ns/10ps
module sicsd_props
    import sicsd_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire sicsd_wb_req_s WB_REQ,
    input wire sicsd_wb_rsp_s WB_RSP,
    input wire sicsd_link_in_s LINK_IN,
    input wire sicsd_link_out_s LINK_OUT,
    input wire logic CHECKSUM_MISMATCH,
    input wire logic IRQ,
    input wire logic TX_DMA_REQ,
    input wire logic RX_DMA_REQ
);
    logic [7:0] ctl2;
    logic [7:0] c1;
    logic [7:0] c2;
    logic wide;
    wire logic take = WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
    // Enable bit counts as off only when low for three samples, covering output latency
    wire logic [7:0] off = ~(ctl2 | c1 | c2);
    wire logic [7:0] a = WB_REQ.adr;
    wire logic mapped = a == 8'h00 || a == 8'h04 || a == 8'h08 || a == 8'h0c || a == 8'h1c;

    // ------------------------------------------------------------------
    // Shadow of control bits, taken at the edge the block takes a write
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctl2 <= 8'h00;
            c1 <= 8'h00;
            c2 <= 8'h00;
            wide <= 1'b0;
        end else begin
            c1 <= ctl2;
            c2 <= c1;
            if (take && WB_REQ.we && a == ADDR_CONTROL_SECOND && WB_REQ.sel[0]) begin
                ctl2 <= WB_REQ.dat[7:0];
            end
            if (take && WB_REQ.we && a == ADDR_CONTROL_FIRST && WB_REQ.sel[1]) begin
                wide <= WB_REQ.dat[CF_WIDE_FRAME];
            end
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence take_s;
        take;
    endsequence
    sequence rd_ack_s(logic [7:0] adr);
        WB_RSP.ack && !WB_REQ.we && a == adr;
    endsequence

    ack_follows_a: assert property (take_s |=> WB_RSP.ack) else $error("ack missing after request");
    ack_pulse_a: assert property (WB_RSP.ack |=> !WB_RSP.ack) else $error("ack held too long");
    reset_quiet_a: assert property (disable iff (1'b0) RST |=> !WB_RSP.ack && !IRQ && !TX_DMA_REQ && !RX_DMA_REQ)
        else $error("outputs active after reset");
    irq_gated_a: assert property (&off[7:5] |-> !IRQ) else $error("irq without enable");
    tx_dma_gate_a: assert property (off[1] |-> !TX_DMA_REQ) else $error("tx dma without enable");
    rx_dma_gate_a: assert property (off[0] |-> !RX_DMA_REQ) else $error("rx dma without enable");
    sel_drive_gate_a: assert property (off[2] |-> !LINK_OUT.select_oe) else $error("select driven");
    ctl2_readback_a: assert property (rd_ack_s(ADDR_CONTROL_SECOND) |-> WB_RSP.dat == {24'h0, ctl2})
        else $error("control readback wrong");
    narrow_read_a: assert property (rd_ack_s(ADDR_WORD_PORT) |-> wide || WB_RSP.dat[31:8] == 24'h0)
        else $error("narrow word has high bits");
    flags_spare_a: assert property (rd_ack_s(ADDR_FLAGS) |-> WB_RSP.dat[31:9] == 23'h0)
        else $error("flags spare bits set");
    unmapped_zero_a: assert property (WB_RSP.ack && !WB_REQ.we && !mapped |-> WB_RSP.dat == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind sicsd_regs sicsd_props chk (.CLOCK(CLOCK), .RST(RST), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP), .LINK_IN(LINK_IN),
    .LINK_OUT(LINK_OUT), .CHECKSUM_MISMATCH(CHECKSUM_MISMATCH), .IRQ(IRQ), .TX_DMA_REQ(TX_DMA_REQ),
    .RX_DMA_REQ(RX_DMA_REQ));

/* test/sicsd_link_peer.sv */
// Serial master model on the far side of the link
`timescale 1ns/10ps
module sicsd_link_peer
    import sicsd_pkg::*;
(
    output sicsd_link_in_s LINK,
    input wire logic MISO
);
    logic cpha;
    initial begin
        cpha = 1'b0;
        LINK = '{sck: 1'b0, mosi: 1'b0, select_in: 1'b1};
    end

    // One frame, MSB first; the clock stands still outside frames
    task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        #7 LINK.select_in = 1'b0;
        #150;
        for (i = n - 1; i >= 0; i--) begin
            if (!cpha) LINK.mosi = tx[i];
            #100 LINK.sck = 1'b1;
            if (cpha) LINK.mosi = tx[i];
            else rx[i] = MISO;
            #100 LINK.sck = 1'b0;
            if (cpha) rx[i] = MISO;
        end
        #150 LINK.select_in = 1'b1;
        // Released line shows the inverse so a stale value cannot pass
        LINK.mosi = ~LINK.mosi;
    endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the serial register block
`timescale 1ns/10ps
module tb
    import sicsd_pkg::*;
;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    sicsd_wb_req_s wb_req = '0;
    sicsd_wb_rsp_s wb_rsp;
    sicsd_link_in_s link_in;
    sicsd_link_out_s link_out;
    logic cks_bad = 1'b0;
    logic irq;
    logic tx_dma;
    logic rx_dma;
    int errors = 0;
    int cmp_count = 0;

    sicsd_regs uut (.CLOCK(CLOCK), .RST(RST), .WB_REQ(wb_req), .WB_RSP(wb_rsp), .LINK_IN(link_in),
        .LINK_OUT(link_out), .CHECKSUM_MISMATCH(cks_bad), .IRQ(irq), .TX_DMA_REQ(tx_dma), .RX_DMA_REQ(rx_dma));
    sicsd_link_peer peer (.LINK(link_in), .MISO(link_out.miso));

    always #12.5 CLOCK = ~CLOCK;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", w, exp, seen);
        end
    endtask
    // Classic cycle: request held until ack is sampled high, then released
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q);
        @(posedge CLOCK);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
        @(posedge CLOCK);
        while (wb_rsp.ack !== 1'b1) @(posedge CLOCK);
        q = wb_rsp.dat;
        wb_req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask
    task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        check(w, q, e);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdc("flags", ADDR_FLAGS, FLAGS_RESET);
        rdc("ctl2", ADDR_CONTROL_SECOND, 32'h0);
        rdc("word", ADDR_WORD_PORT, 32'h0);
        wr(8'h10, 32'hffff);
        rdc("unmapped", 8'h10, 32'h0);
    endtask
    // Each enable alone; only tx empty is pending, so only its gates may fire
    // Master role without enable: select drive takes effect, no fault condition arises
    task automatic t_ctl2();
        int i;
        wr(ADDR_CONTROL_FIRST, 32'h4);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_CONTROL_SECOND, 32'h1 << i);
            rdc("ctl2", ADDR_CONTROL_SECOND, 32'h1 << i);
            check("irq", 32'(irq), 32'(i == 7));
            check("txdma", 32'(tx_dma), 32'(i == 1));
            check("rxdma", 32'(rx_dma), 32'h0);
            check("seloe", 32'(link_out.select_oe), 32'(i == 2));
        end
    endtask
    task automatic t_frame(input logic ph, input logic wd, input logic [15:0] tw, input logic [15:0] rw);
        logic [15:0] got;
        logic [31:0] m;
        m = wd ? 32'hffff : 32'hff;
        wr(ADDR_CONTROL_FIRST, 32'h40 | 32'(ph) | (32'(wd) << 11));
        wr(ADDR_CONTROL_SECOND, 32'h01);
        wr(ADDR_WORD_PORT, {16'h0, tw});
        rdc("loaded", ADDR_FLAGS, 32'h0);
        peer.cpha = ph;
        fork
            peer.frame(rw, wd ? 16 : 8, got);
            begin
                repeat (40) @(posedge CLOCK);
                rdc("active", ADDR_FLAGS, 32'h82);
            end
        join
        repeat (8) @(posedge CLOCK);
        check("sent", {16'h0, got}, {16'h0, tw} & m);
        check("rxdma", 32'(rx_dma), 32'h1);
        rdc("filled", ADDR_FLAGS, 32'h3);
        rdc("word", ADDR_WORD_PORT, {16'h0, rw} & m);
        rdc("drained", ADDR_FLAGS, 32'h2);
    endtask
    // Second word lands on a full buffer; a flags read alone must not clear
    task automatic t_overrun();
        logic [15:0] got;
        wr(ADDR_CONTROL_FIRST, 32'h840);
        wr(ADDR_CONTROL_SECOND, 32'h20);
        peer.cpha = 1'b0;
        peer.frame(16'h1234, 16, got);
        peer.frame(16'hbeef, 16, got);
        repeat (8) @(posedge CLOCK);
        check("errirq", 32'(irq), 32'h1);
        rdc("overrun", ADDR_FLAGS, 32'h43);
        rdc("word", ADDR_WORD_PORT, 32'h1234);
        rdc("overrun", ADDR_FLAGS, 32'h42);
        rdc("cleared", ADDR_FLAGS, 32'h2);
        check("errirq", 32'(irq), 32'h0);
    endtask
    task automatic t_checksum();
        logic [31:0] q;
        @(posedge CLOCK);
        cks_bad <= 1'b1;
        @(posedge CLOCK);
        cks_bad <= 1'b0;
        rdc("cksum", ADDR_FLAGS, 32'h12);
        check("errirq", 32'(irq), 32'h1);
        bus(1'b1, ADDR_FLAGS, 32'h10, 4'h3, q);
        rdc("cksum", ADDR_FLAGS, 32'h12);
        bus(1'b1, ADDR_FLAGS, 32'h0, 4'h1, q);
        rdc("cksum", ADDR_FLAGS, 32'h2);
    endtask
    task automatic t_config();
        wr(ADDR_CONTROL_FIRST, 32'h244);
        repeat (4) @(posedge CLOCK);
        rdc("config", ADDR_FLAGS, 32'h22);
        // The old setting still raises the fault at the edge of this write, and a set wins
        wr(ADDR_CONTROL_FIRST, 32'h0);
        rdc("config", ADDR_FLAGS, 32'h22);
        wr(ADDR_CONTROL_FIRST, 32'h0);
        rdc("config", ADDR_FLAGS, 32'h2);
    endtask
    // Audio frame with an empty transmit buffer: underrun, then the side flips to right
    task automatic t_audio();
        logic [15:0] got;
        wr(ADDR_AUDIO_CONTROL, 32'h800);
        wr(ADDR_CONTROL_FIRST, 32'h40);
        peer.frame(16'h005a, 8, got);
        repeat (8) @(posedge CLOCK);
        rdc("audio", ADDR_FLAGS, 32'hf);
        rdc("word", ADDR_WORD_PORT, 32'h5a);
        rdc("audio", ADDR_FLAGS, 32'h6);
        wr(ADDR_AUDIO_CONTROL, 32'h0);
        rdc("audio", ADDR_FLAGS, 32'h2);
    endtask
    // Master with soft select high: a word write pulses select for one cycle
    task automatic t_pulse();
        wr(ADDR_CONTROL_FIRST, 32'h344);
        wr(ADDR_CONTROL_SECOND, 32'h0c);
        check("selout", 32'(link_out.select_out), 32'h0);
        wr(ADDR_WORD_PORT, 32'h11);
        check("selout", 32'(link_out.select_out), 32'h1);
        @(posedge CLOCK);
        check("selout", 32'(link_out.select_out), 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge CLOCK);
        RST <= 1'b0;
        t_reset();
        t_ctl2();
        t_frame(1'b0, 1'b0, 16'ha5c3, 16'h5a3c);
        t_frame(1'b1, 1'b1, 16'hc3a5, 16'h9e71);
        t_overrun();
        t_checksum();
        t_config();
        t_audio();
        t_pulse();
        end_sim();
    end
    // Whole run needs under a thousand cycles; this margin only catches a hang
    initial begin
        repeat (20000) @(posedge CLOCK);
        errors++;
        end_sim();
    end
endmodule
